// ### rtl/ldc_config_latches.sv
// Configuration latch bank, serial ports, status readback and gray counter.
`timescale 1ns/1ps
`include "ldc_consts.svh"

module ldc_config_latches #(
  parameter int LATCH_DELAY_CYC = `LDC_LATCH_MIN_CYC,
  parameter int FIFO_DEPTH      = `LDC_FIFO_DEPTH
) (
  input  wire logic                          ref_clk,
  input  wire logic                          srst,
  input  wire logic                          clk_en,
  input  wire logic                          config_port_serial_clock,
  input  wire logic                          config_port_serial_in,
  output logic                               config_port_serial_out,
  input  wire logic                          gray_port_serial_clock,
  input  wire logic                          gray_port_serial_in,
  output logic                               gray_port_serial_out,
  input  wire logic                          gray_latch_strobe,
  input  wire logic                          output_blank_n,
  input  wire logic                          pwm_clock_red,
  input  wire logic [`LDC_NUM_CH-1:0]        open_led_flag,
  input  wire logic [`LDC_NUM_CH-1:0]        short_led_flag,
  input  wire logic                          overtemp_flag,
  output ldc_pkg::ldc_cfg_word_t             config_latch,
  output logic      [`LDC_USER_W-1:0]        user_scratch,
  output logic      [`LDC_COMMON_W-1:0]      gray_level,
  output logic      [`LDC_GRAY_W-1:0]        gray_count,
  output logic                               outputs_off,
  output logic                               config_bit_dropped
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  localparam int PW = 7 + 2*`LDC_NUM_CH + 1;
  localparam int TW = $clog2(LATCH_DELAY_CYC + 1);

  logic [PW-1:0] pin_meta;
  logic [PW-1:0] pin_sync;
  logic [3:0]    edge_prev;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (clk_en) begin
      pin_meta <= {overtemp_flag, short_led_flag, open_led_flag,
                   pwm_clock_red, output_blank_n, gray_latch_strobe,
                   gray_port_serial_in, gray_port_serial_clock,
                   config_port_serial_in, config_port_serial_clock};
      pin_sync <= pin_meta;
    end
  end

  wire                   c_clk   = pin_sync[0];
  wire                   c_in    = pin_sync[1];
  wire                   g_clk   = pin_sync[2];
  wire                   g_in    = pin_sync[3];
  wire                   lat_lvl = pin_sync[4];
  wire                   blank_n = pin_sync[5];
  wire                   p_clk   = pin_sync[6];
  wire [`LDC_NUM_CH-1:0] open_s  = pin_sync[7 +: `LDC_NUM_CH];
  wire [`LDC_NUM_CH-1:0] short_s = pin_sync[7+`LDC_NUM_CH +: `LDC_NUM_CH];
  wire                   temp_s  = pin_sync[PW-1];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      edge_prev <= '0;
    end else if (clk_en) begin
      edge_prev <= {p_clk, lat_lvl, g_clk, c_clk};
    end
  end

  wire c_rise   = c_clk & ~edge_prev[0];
  wire g_rise   = g_clk & ~edge_prev[1];
  wire lat_rise = lat_lvl & ~edge_prev[2];
  wire p_rise   = p_clk & ~edge_prev[3];

  // ---------------------------------------------------------------------------
  // Config port: bit FIFO feeding the 216-bit shift register
  // ---------------------------------------------------------------------------
  logic [`LDC_CFG_SR_W-1:0] cfg_shift;
  logic [`LDC_COMMON_W-1:0] common;
  logic                     last_lat;
  logic                     cfg_pend;
  logic [TW-1:0]            cfg_timer;
  logic                     fifo_in_ready;
  logic                     fifo_out_valid;
  logic                     fifo_out_data;

  wire gray_cfg_load = lat_rise & last_lat;
  wire gray_gs_load  = lat_rise & ~last_lat;
  // The shift register cannot take a bit while the gray port rewrites it.
  wire fifo_pop_ok   = ~gray_cfg_load;
  wire cfg_pop       = fifo_out_valid & fifo_pop_ok;
  wire timer_done    = (cfg_timer >= TW'(LATCH_DELAY_CYC));
  wire cfg_fire      = cfg_pend & timer_done & ~fifo_out_valid;

  ldc_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_cfg_fifo (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .clk_en    (clk_en),
    .in_valid  (c_rise),
    .in_ready  (fifo_in_ready),
    .in_data   (c_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop_ok),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_shift <= '0;
    end else if (clk_en) begin
      if (gray_cfg_load) begin
        cfg_shift[`LDC_CFG_SR_W-1:`LDC_USER_LSB] <=
          common[`LDC_CFG_SR_W-1:`LDC_USER_LSB];
      end else if (cfg_pop) begin
        cfg_shift <= {cfg_shift[`LDC_CFG_SR_W-2:0], fifo_out_data};
      end
    end
  end

  // A new config clock restarts the idle wait; the strobe fires once.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_pend           <= 1'b0;
      cfg_timer          <= '0;
      config_bit_dropped <= 1'b0;
    end else if (clk_en) begin
      if (c_rise) begin
        cfg_pend  <= 1'b1;
        cfg_timer <= '0;
      end else if (cfg_fire) begin
        cfg_pend  <= 1'b0;
      end else if (cfg_pend & ~timer_done) begin
        cfg_timer <= cfg_timer + 1'b1;
      end
      if (c_rise & ~fifo_in_ready) begin
        config_bit_dropped <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Latches and status word
  // ---------------------------------------------------------------------------
  ldc_pkg::ldc_cfg_word_t next_cfg;
  ldc_pkg::ldc_status_t   stat_word;
  logic [`LDC_USER_W-1:0] next_user;

  // Gray port load wins over the config port strobe in the same cycle.
  assign next_cfg  = gray_cfg_load ? common[`LDC_LATCH_W-1:0] :
                     cfg_fire      ? cfg_shift[`LDC_LATCH_W-1:0] :
                     config_latch;
  assign next_user = (cfg_fire & ~gray_cfg_load) ?
                     cfg_shift[`LDC_CFG_SR_W-1:`LDC_USER_LSB] :
                     user_scratch;
  // Flags, reserved zeros, user bits and the latch just written.
  assign stat_word = {open_s, short_s, temp_s,
                      {`LDC_STAT_RSVD_W{1'b0}},
                      next_user, next_cfg};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      config_latch <= '0;
      user_scratch <= '0;
      gray_level   <= '0;
    end else if (clk_en) begin
      config_latch <= next_cfg;
      user_scratch <= next_user;
      if (gray_gs_load) begin
        gray_level <= common;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      common   <= '0;
      last_lat <= 1'b0;
    end else if (clk_en) begin
      if (lat_rise) begin
        common <= stat_word;
      end else if (g_rise) begin
        common   <= {common[`LDC_COMMON_W-2:0], g_in};
        last_lat <= lat_lvl;
      end
    end
  end

  assign gray_port_serial_out   = common[`LDC_COMMON_W-1];
  assign config_port_serial_out = cfg_shift[`LDC_CFG_SR_W-1];

  // ---------------------------------------------------------------------------
  // Grayscale counter window
  // ---------------------------------------------------------------------------
  ldc_pkg::ldc_func_t     fc;
  ldc_pkg::ldc_pwm_state_t pwm_state;
  ldc_pkg::ldc_pwm_state_t next_state;
  logic [`LDC_GRAY_W-1:0] next_count;
  logic [`LDC_GRAY_W-1:0] period_end;

  assign fc = config_latch.func;
  // Range bits and brightness bytes reach the analog sinks through
  // config_latch; nothing inside this block reads them.
  assign period_end = ~fc.mode[1] ? `LDC_END_12BIT :
                      fc.mode[0]  ? `LDC_END_8BIT : `LDC_END_10BIT;
  wire timing_kill  = gray_gs_load & fc.treset;

  always_comb begin
    next_state = pwm_state;
    next_count = gray_count;
    if (~blank_n) begin
      next_state = ldc_pkg::LDC_PWM_IDLE;
      next_count = '0;
    end else if (timing_kill) begin
      next_state = ldc_pkg::LDC_PWM_IDLE;
      next_count = '0;
    end else if (p_rise) begin
      case (pwm_state)
        ldc_pkg::LDC_PWM_IDLE: begin
          next_state = ldc_pkg::LDC_PWM_RUN;
          next_count = '0;
        end
        ldc_pkg::LDC_PWM_RUN: begin
          if (gray_count != period_end) begin
            next_count = gray_count + 1'b1;
          end else if (fc.auto_rep) begin
            next_count = '0;
          end else begin
            next_state = ldc_pkg::LDC_PWM_DONE;
          end
        end
        default: begin
          next_state = ldc_pkg::LDC_PWM_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwm_state   <= ldc_pkg::LDC_PWM_IDLE;
      gray_count  <= '0;
      outputs_off <= 1'b1;
    end else if (clk_en) begin
      pwm_state   <= next_state;
      gray_count  <= next_count;
      outputs_off <= (next_state != ldc_pkg::LDC_PWM_RUN) |
                     (next_count == period_end);
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst || !clk_en);

  // Only meaningful for idle delays of eight cycles or more.
  property p_cfg_strobe_late;
    c_rise |=> (!cfg_fire) [*8];
  endproperty
  a_cfg_strobe_late: assert property (p_cfg_strobe_late)
    else $error("config strobe before idle delay");

  property p_cfg_copy;
    cfg_fire && !gray_cfg_load |=>
      config_latch == $past(cfg_shift[`LDC_LATCH_W-1:0]);
  endproperty
  a_cfg_copy: assert property (p_cfg_copy)
    else $error("config latch not copied from shift register");

  property p_gray_cfg;
    gray_cfg_load |=> config_latch == $past(common[`LDC_LATCH_W-1:0])
      && cfg_shift[`LDC_CFG_SR_W-1:`LDC_USER_LSB] ==
         $past(common[`LDC_CFG_SR_W-1:`LDC_USER_LSB]);
  endproperty
  a_gray_cfg: assert property (p_gray_cfg)
    else $error("gray port config load wrong");

  property p_status;
    lat_rise |=> common[`LDC_COMMON_W-1 -: `LDC_NUM_CH] == $past(open_s)
      && common[`LDC_STAT_TEMP_BIT] == $past(temp_s)
      && common[`LDC_STAT_TEMP_BIT-1 -: `LDC_STAT_RSVD_W] == '0;
  endproperty
  a_status: assert property (p_status)
    else $error("status word not loaded");

  property p_cfg_shift;
    cfg_pop && !gray_cfg_load |=> cfg_shift[0] == $past(fifo_out_data)
      && cfg_shift[`LDC_CFG_SR_W-1:1] == $past(cfg_shift[`LDC_CFG_SR_W-2:0]);
  endproperty
  a_cfg_shift: assert property (p_cfg_shift)
    else $error("config shift register did not shift");

  property p_blank;
    !blank_n |=> outputs_off && gray_count == '0;
  endproperty
  a_blank: assert property (p_blank)
    else $error("outputs not forced off by blank");

  property p_single;
    pwm_state == ldc_pkg::LDC_PWM_DONE && blank_n && !timing_kill |=>
      pwm_state == ldc_pkg::LDC_PWM_DONE && outputs_off;
  endproperty
  a_single: assert property (p_single)
    else $error("PWM restarted without auto repeat");

  property p_repeat;
    pwm_state == ldc_pkg::LDC_PWM_RUN && p_rise && blank_n && !timing_kill
      && fc.auto_rep && gray_count == period_end |=>
      pwm_state == ldc_pkg::LDC_PWM_RUN && gray_count == '0;
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("auto repeat did not restart");

  property p_treset;
    timing_kill && blank_n |=> outputs_off && gray_count == '0
      && pwm_state == ldc_pkg::LDC_PWM_IDLE;
  endproperty
  a_treset: assert property (p_treset)
    else $error("timing reset ignored");

  property p_end_off;
    pwm_state == ldc_pkg::LDC_PWM_RUN && gray_count == period_end
      |-> outputs_off;
  endproperty
  a_end_off: assert property (p_end_off)
    else $error("output on at period end");

  property p_user_hold;
    !cfg_fire |=> $stable(user_scratch);
  endproperty
  a_user_hold: assert property (p_user_hold)
    else $error("user bits changed without strobe");

  c_cfg_fire:  cover property (cfg_fire);
  c_gray_cfg:  cover property (gray_cfg_load);
  c_wrap:      cover property (pwm_state == ldc_pkg::LDC_PWM_RUN && p_rise
                               && fc.auto_rep && gray_count == period_end);
  c_treset:    cover property (timing_kill);

endmodule // ldc_config_latches

// ### rtl/ldc_consts.svh
// Field positions, widths and timing counts of the LED driver latch bank.
`ifndef LDC_CONSTS_SVH
`define LDC_CONSTS_SVH

// -----------------------------------------------------------------------------
// Clock and timing
// -----------------------------------------------------------------------------
`define LDC_CLK_HZ          50000000
`define LDC_LATCH_MIN_MS    3
`define LDC_LATCH_MAX_MS    7
`define LDC_LATCH_MIN_CYC   (`LDC_LATCH_MIN_MS * (`LDC_CLK_HZ / 1000))
`define LDC_LATCH_MAX_CYC   (`LDC_LATCH_MAX_MS * (`LDC_CLK_HZ / 1000))
`define LDC_SYNC_STAGES     2

// -----------------------------------------------------------------------------
// Combined configuration latch layout
// -----------------------------------------------------------------------------
`define LDC_NUM_CH          24
`define LDC_TRIM_W          7
`define LDC_TRIM_LSB        0
`define LDC_BRIGHT_LSB      168
`define LDC_BRIGHT_W        8
`define LDC_FUNC_LSB        192
`define LDC_FUNC_W          7
`define LDC_USER_LSB        199
`define LDC_USER_W          17
`define LDC_LATCH_W         199
`define LDC_CFG_SR_W        216
`define LDC_COMMON_W        288
`define LDC_STAT_RSVD_W     23
`define LDC_STAT_TEMP_BIT   239

// -----------------------------------------------------------------------------
// Grayscale counter
// -----------------------------------------------------------------------------
`define LDC_GRAY_W          12
`define LDC_END_12BIT       12'hFFF
`define LDC_END_10BIT       12'h3FF
`define LDC_END_8BIT        12'h0FF
`define LDC_FIFO_DEPTH      8

`endif

// ### rtl/ldc_pkg.sv
// Types shared by the LED driver latch bank.
`include "ldc_consts.svh"

package ldc_pkg;

  // ---------------------------------------------------------------------------
  // Configuration and status words
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mode;
    logic       treset;
    logic       auto_rep;
    logic [2:0] range;
  } ldc_func_t;

  typedef struct packed {
    ldc_func_t                                  func;
    logic [3*`LDC_BRIGHT_W-1:0]                 bright;
    logic [`LDC_NUM_CH*`LDC_TRIM_W-1:0]         trim;
  } ldc_cfg_word_t;

  typedef struct packed {
    logic [`LDC_NUM_CH-1:0]      open_f;
    logic [`LDC_NUM_CH-1:0]      short_f;
    logic                        temp;
    logic [`LDC_STAT_RSVD_W-1:0] rsvd;
    logic [`LDC_USER_W-1:0]      user;
    ldc_cfg_word_t               cfg;
  } ldc_status_t;

  typedef enum logic [1:0] {
    LDC_PWM_IDLE = 2'b00,
    LDC_PWM_RUN  = 2'b01,
    LDC_PWM_DONE = 2'b10
  } ldc_pwm_state_t;

endpackage

// ### rtl/ldc_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps

module ldc_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;

  wire push = in_valid & in_ready & clk_en;
  wire pop  = out_valid & out_ready & clk_en;

  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        fill <= fill + 1'b1;
      end else if (pop & ~push) begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule // ldc_fifo

// ### dv/ldc_ctrl_model.sv
// Display controller model driving both serial ports of the latch bank.
`timescale 1ns/1ps
`include "ldc_consts.svh"

module ldc_ctrl_model (
  input  wire logic ref_clk,
  output logic      config_port_serial_clock,
  output logic      config_port_serial_in,
  output logic      gray_port_serial_clock,
  output logic      gray_port_serial_in,
  output logic      gray_latch_strobe,
  input  wire logic gray_port_serial_out
);
  initial begin
    config_port_serial_clock = 1'b0;
    config_port_serial_in    = 1'b0;
    gray_port_serial_clock   = 1'b0;
    gray_port_serial_in      = 1'b0;
    gray_latch_strobe        = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Half a link period is four system cycles; clocks idle low between words.
  task automatic cfg_write(input logic [`LDC_CFG_SR_W-1:0] w);
    for (int i = `LDC_CFG_SR_W - 1; i >= 0; i--) begin
      config_port_serial_in = w[i];
      tick(4);
      config_port_serial_clock = 1'b1;
      tick(4);
      config_port_serial_clock = 1'b0;
    end
    config_port_serial_in = ~w[0];
  endtask

  // The strobe level at the last edge picks the target latch. A config
  // write holds it high for the whole word, so its first rise latches the
  // old word into the latch picked by the previous transfer's last edge;
  // the closing rise then loads the config latch.
  task automatic gray_xfer(input  logic [`LDC_COMMON_W-1:0] w,
                           input  logic                     to_cfg,
                           output logic [`LDC_COMMON_W-1:0] r);
    gray_latch_strobe = to_cfg;
    for (int i = `LDC_COMMON_W - 1; i >= 0; i--) begin
      gray_port_serial_in = w[i];
      tick(4);
      r[i] = gray_port_serial_out;
      gray_port_serial_clock = 1'b1;
      tick(4);
      gray_port_serial_clock = 1'b0;
    end
    gray_port_serial_in = ~w[0];
    gray_latch_strobe   = 1'b0;
    tick(4);
    gray_latch_strobe = 1'b1;
    tick(4);
    gray_latch_strobe = 1'b0;
    tick(6);
  endtask
endmodule // ldc_ctrl_model

// ### dv/led_driver_config_latches_test.sv
// Self-checking bench for the LED driver configuration latch bank.
`timescale 1ns/1ps
`include "ldc_consts.svh"

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end

module led_driver_config_latches_test;
  localparam int         DLY = 20;
  localparam logic [2:0] MODES [4] = '{3'h7, 3'h5, 3'h3, 3'h6};
  logic                   ref_clk  = 1'b0;
  logic                   srst     = 1'b1;
  logic                   blank_n  = 1'b0;
  logic                   pwm      = 1'b0;
  logic                   temp     = 1'b0;
  logic [23:0]            open_f   = 24'h0;
  logic [23:0]            short_f  = 24'h0;
  logic [198:0]           cfg_q;
  logic [16:0]            user_q;
  logic [31:0]            seed     = 32'hE88A;
  int                     err_total = 0;
  int                     compares  = 0;
  wire logic              cpc, cpi, cpo, gpc, gpi, gpo, gls;
  ldc_pkg::ldc_cfg_word_t config_latch;
  logic [16:0]            user_scratch;
  logic [287:0]           gray_level;
  logic [11:0]            gray_count;
  logic                   outputs_off;
  logic                   dropped;

  always #10 ref_clk = ~ref_clk;

  ldc_config_latches #(.LATCH_DELAY_CYC(DLY), .FIFO_DEPTH(8)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .clk_en(1'b1),
    .config_port_serial_clock(cpc), .config_port_serial_in(cpi),
    .config_port_serial_out(cpo), .gray_port_serial_clock(gpc),
    .gray_port_serial_in(gpi), .gray_port_serial_out(gpo),
    .gray_latch_strobe(gls), .output_blank_n(blank_n),
    .pwm_clock_red(pwm), .open_led_flag(open_f),
    .short_led_flag(short_f), .overtemp_flag(temp),
    .config_latch(config_latch), .user_scratch(user_scratch),
    .gray_level(gray_level), .gray_count(gray_count),
    .outputs_off(outputs_off), .config_bit_dropped(dropped));

  ldc_ctrl_model u_ctrl (
    .ref_clk(ref_clk), .config_port_serial_clock(cpc),
    .config_port_serial_in(cpi), .gray_port_serial_clock(gpc),
    .gray_port_serial_in(gpi), .gray_latch_strobe(gls),
    .gray_port_serial_out(gpo));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [11:0] end_of(input logic [1:0] m);
    return m[1] ? (m[0] ? 12'h0FF : 12'h3FF) : 12'hFFF;
  endfunction

  function automatic logic [287:0] status_of();
    return {open_f, short_f, temp, 23'h0, user_q, cfg_q};
  endfunction

  task automatic rnd(output logic [287:0] v);
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      v[i*32 +: 32] = seed;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic pwm_pulse();
    pwm = 1'b1;
    tick(4);
    pwm = 1'b0;
    tick(4);
  endtask

  task automatic test_done();
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [287:0] v, w, r, st;
    logic [11:0]  e;
    tick(2);
    srst = 1'b0;
    `CHK(config_latch, 199'h0);
    `CHK(outputs_off, 1'b1);
    rnd(v);
    u_ctrl.cfg_write(v[215:0]);
    tick(4);
    `CHK(config_latch, 199'h0);
    tick(DLY + 30);
    `CHK(config_latch, v[198:0]);
    `CHK(user_scratch, v[215:199]);
    `CHK(cpo, v[215]);
    cfg_q  = v[198:0];
    user_q = v[215:199];
    rnd(r);
    {temp, short_f, open_f} = r[48:0];
    rnd(w);
    u_ctrl.gray_xfer(w, 1'b0, r);
    `CHK(gray_level, w);
    st = status_of();
    rnd(v);
    u_ctrl.gray_xfer(v, 1'b1, r);
    `CHK(r, st);
    `CHK(config_latch, v[198:0]);
    `CHK(user_scratch, user_q);
    `CHK(cpo, v[215]);
    // Timing reset stays on so every mode can be restarted by a latch edge.
    for (int k = 0; k < 4; k++) begin
      blank_n = 1'b0;
      rnd(v);
      v[198:192] = {MODES[k][2:1], 1'b1, MODES[k][0], 3'h0};
      u_ctrl.gray_xfer(v, 1'b1, r);
      `CHK(outputs_off, 1'b1);
      blank_n = 1'b1;
      e = end_of(MODES[k][2:1]);
      repeat (e + 1) pwm_pulse();
      `CHK(gray_count, e);
      `CHK(outputs_off, 1'b1);
      pwm_pulse();
      `CHK(outputs_off, ~MODES[k][0]);
      if (MODES[k][0]) `CHK(gray_count, 12'h000);
      rnd(w);
      u_ctrl.gray_xfer(w, 1'b0, r);
      `CHK({gray_count, outputs_off}, 13'h0001);
      pwm_pulse();
      `CHK(outputs_off, 1'b0);
    end
    // Without timing reset a gray latch edge leaves the counter running.
    blank_n = 1'b0;
    rnd(v);
    v[198:192] = 7'h60;
    u_ctrl.gray_xfer(v, 1'b1, r);
    blank_n = 1'b1;
    repeat (3) pwm_pulse();
    rnd(w);
    u_ctrl.gray_xfer(w, 1'b0, r);
    `CHK({gray_count, outputs_off}, 13'h0004);
    `CHK(gray_level, w);
    repeat (254) pwm_pulse();
    `CHK({gray_count, outputs_off}, 13'h01FF);
    blank_n = 1'b0;
    tick(4);
    `CHK({gray_count, outputs_off}, 13'h0001);
    `CHK(dropped, 1'b0);
    test_done();
  end

  // The run needs about 77000 cycles; the limit keeps a hang short.
  initial begin
    repeat (95000) @(posedge ref_clk);
    err_total++;
    test_done();
  end
endmodule // led_driver_config_latches_test
